//--- common/sbtc_line_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the long-low reset event from the line watcher to the command core
interface sbtc_line_if;
   logic line_reset;
   modport watcher (output line_reset);
   modport core (input line_reset);
endinterface
`default_nettype wire

//--- common/sbtc_pkg.sv
// What this block does
// - Order: init, selection, function, else silent
// - Every transaction opens with reset and presence
// - Decode five 8-bit selection commands after init
// - Read-identity sends all 64 identity bits
// - Match: respond only when all 64 bits match
// - Skip selection addresses every device at once
// - Alarm search joins only with alarm set
// - Conversion stores two-byte temperature, then idles
// - Read slots show 0 converting, 1 done
// - Scratchpad write fills thresholds then configuration
// - Scratchpad read sends bytes 0..8, LSB first
// - Reset abandons a scratchpad read early
// - Copy saves thresholds and configuration to nonvolatile
// - Recall reloads thresholds and configuration from nonvolatile
// - Read slots show 0 recalling, 1 done
// - Recall runs automatically at power-up
// - All bits travel least significant first
// - Line low over 480 us resets transaction
// - Identity: family low, serial, CRC top
// - CRC x^8+x^5+x^4+1 from zero, bit order
`default_nettype none
package sbtc_pkg;
   // Selection commands
   localparam logic [7:0] CMD_SEARCH = 8'hf0;
   localparam logic [7:0] CMD_READ_ID = 8'h33;
   localparam logic [7:0] CMD_MATCH = 8'h55;
   localparam logic [7:0] CMD_SKIP = 8'hcc;
   localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
   // Function commands
   localparam logic [7:0] CMD_CONVERT = 8'h44;
   localparam logic [7:0] CMD_WR_SCRATCH = 8'h4e;
   localparam logic [7:0] CMD_RD_SCRATCH = 8'hbe;
   localparam logic [7:0] CMD_COPY = 8'h48;
   localparam logic [7:0] CMD_NV_TO_SCRATCH = 8'hb8;

   // Bit counts of each phase
   localparam logic [6:0] CMD_BITS = 7'd8;
   localparam logic [6:0] ID_BITS = 7'd64;
   localparam logic [6:0] WR_SCRATCH_BITS = 7'd24;
   localparam logic [6:0] RD_SCRATCH_BITS = 7'd72;
   localparam logic [6:0] CRC_FIRST_BIT = 7'd64;

   // Timing, 100 MHz core clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_LOW_NS = 480000;
   localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_RECALL_NS = 10000;
   localparam int NV_RECALL_CYC = (NV_RECALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] NV_RECALL_CNT = 16'(NV_RECALL_CYC);

   // Scratchpad reset values and fixed bytes
   localparam logic [7:0] HIGH_ALARM_RST = 8'h4b;
   localparam logic [7:0] LOW_ALARM_RST = 8'h46;
   localparam logic [7:0] CFG_RST = 8'h7f;
   localparam logic [7:0] CFG_WR_MASK = 8'h60;
   localparam logic [7:0] CFG_FIXED = 8'h1f;
   localparam logic [15:0] TEMP_RST = 16'h0550;
   localparam logic [7:0] RSVD_BYTE5 = 8'hff;
   localparam logic [7:0] RSVD_BYTE6 = 8'h00;
   localparam logic [7:0] RSVD_BYTE7 = 8'h10;

   // Wishbone register byte offsets
   localparam logic [7:0] REG_TEMP_IN = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_SCRATCH = 8'h0c;
   localparam logic [7:0] REG_NV = 8'h10;
   localparam logic [7:0] REG_TEMP = 8'h14;
   localparam int CTRL_CONV_DONE_BIT = 0;

   // Reflected form of x^8+x^5+x^4+1
   localparam logic [7:0] CRC_POLY_REFL = 8'h8c;

   typedef enum logic [3:0] {
      ST_IDLE, ST_SEL_CMD, ST_READ_ID, ST_MATCH, ST_SEARCH, ST_FUNC_CMD,
      ST_CONVERT, ST_WR_SCRATCH, ST_RD_SCRATCH, ST_RECALL, ST_HALT
   } sbtc_state_t;

   // One serial CRC step, data bit shifted in LSB first
   function automatic logic [7:0] sbtc_crc_step(input logic [7:0] crc, input logic din);
      logic fb;
      fb = crc[0] ^ din;
      sbtc_crc_step = {1'b0, crc[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
   endfunction

   // CRC of the low 56 identity bits
   function automatic logic [7:0] sbtc_crc56(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
      begin
         c = sbtc_crc_step(c, d[i]);
      end
      sbtc_crc56 = c;
   endfunction
endpackage
`default_nettype wire

//--- core/sbtc_cmd_core.sv
`timescale 1ns/1ps
`default_nettype none
module sbtc_cmd_core
   import sbtc_pkg::*;
#(
   parameter int RESET_CYC = RESET_LOW_CYC,
   parameter logic [7:0] FAMILY_CODE = 8'h5a,  // Arbitrary value
   parameter logic [47:0] SERIAL_NUM = 48'h0123456789ab  // Arbitrary value
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dq_in,
   input wire logic slot_wr_valid,
   input wire logic slot_wr_bit,
   input wire logic slot_rd_req,
   output logic slot_rd_bit,
   output logic conv_active,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import sbtc_pkg::*;

   // Identity layout: family low, serial, CRC on top
   localparam logic [55:0] ID_LOW = {SERIAL_NUM, FAMILY_CODE};
   localparam logic [63:0] ID_CODE = {sbtc_crc56(ID_LOW), ID_LOW};

   sbtc_line_if line ();

   sbtc_line_watch #(
      .RESET_CYC(RESET_CYC)
   ) u_watch (
      .core_clk(core_clk),
      .rst(rst),
      .dq_in(dq_in),
      .line(line)
   );

   sbtc_state_t state_q, state_d;
   logic [6:0] bit_cnt_q, bit_cnt_d;
   logic [1:0] phase_q, phase_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] crc_q, crc_d;
   logic match_ok_q, match_ok_d;
   logic [7:0] high_alarm_threshold_q, high_alarm_threshold_d;
   logic [7:0] low_alarm_threshold_q, low_alarm_threshold_d;
   logic [7:0] cfg_q, cfg_d;
   logic [23:0] nv_q, nv_d;
   logic [15:0] recall_cnt_q, recall_cnt_d;
   logic conv_busy_q, conv_busy_d;
   logic alarm_q, alarm_d;
   logic [15:0] temp_q, temp_d;
   logic rd_bit_q, rd_bit_d;
   logic [15:0] temp_in_q, temp_in_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;

   logic recall_busy;
   logic conv_done_wr;
   logic [7:0] cur_byte;
   logic cur_sp_bit;
   logic id_bit;
   logic [7:0] rx_byte;
   logic [7:0] tmp_hi;

   assign recall_busy = (recall_cnt_q != 16'd0);
   assign id_bit = ID_CODE[bit_cnt_q[5:0]];
   assign rx_byte = {slot_wr_bit, shift_q[7:1]};
   assign tmp_hi = temp_in_q[11:4];
   // Conversion result handed over when software writes the done bit
   assign conv_done_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0]
      && (wb_adr_i == REG_CTRL) && wb_dat_i[CTRL_CONV_DONE_BIT];

   // Scratchpad byte currently being shifted out
   always_comb
   begin
      case (bit_cnt_q[6:3])
         4'd0: cur_byte = temp_q[7:0];
         4'd1: cur_byte = temp_q[15:8];
         4'd2: cur_byte = high_alarm_threshold_q;
         4'd3: cur_byte = low_alarm_threshold_q;
         4'd4: cur_byte = cfg_q;
         4'd5: cur_byte = RSVD_BYTE5;
         4'd6: cur_byte = RSVD_BYTE6;
         4'd7: cur_byte = RSVD_BYTE7;
         default: cur_byte = crc_q;
      endcase
      cur_sp_bit = cur_byte[bit_cnt_q[2:0]];
   end

   // Transaction sequencer, scratchpad and nonvolatile image
   always_comb
   begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      phase_d = phase_q;
      shift_d = shift_q;
      crc_d = crc_q;
      match_ok_d = match_ok_q;
      high_alarm_threshold_d = high_alarm_threshold_q;
      low_alarm_threshold_d = low_alarm_threshold_q;
      cfg_d = cfg_q;
      nv_d = nv_q;
      recall_cnt_d = recall_cnt_q;
      conv_busy_d = conv_busy_q;
      alarm_d = alarm_q;
      temp_d = temp_q;
      // Finished conversion lands in the temperature bytes
      if (conv_done_wr && conv_busy_q)
      begin
         conv_busy_d = 1'b0;
         temp_d = temp_in_q;
         alarm_d = ($signed(tmp_hi) >= $signed(high_alarm_threshold_q))
            || ($signed(tmp_hi) <= $signed(low_alarm_threshold_q));
      end
      // Reload from the nonvolatile image when the recall timer expires
      if (recall_cnt_q == 16'd1)
      begin
         {cfg_d, low_alarm_threshold_d, high_alarm_threshold_d} = nv_q;
      end
      if (recall_busy)
      begin
         recall_cnt_d = recall_cnt_q - 16'd1;
      end
      case (state_q)
         ST_SEL_CMD, ST_FUNC_CMD, ST_MATCH, ST_WR_SCRATCH:
         begin
            if (slot_wr_valid)
            begin
               shift_d = rx_byte;
               bit_cnt_d = bit_cnt_q + 7'd1;
               if (state_q == ST_MATCH && slot_wr_bit != id_bit)
               begin
                  match_ok_d = 1'b0;
               end
               if (state_q == ST_SEL_CMD && bit_cnt_q == CMD_BITS - 7'd1)
               begin
                  bit_cnt_d = 7'd0;
                  phase_d = 2'd0;
                  match_ok_d = 1'b1;
                  case (rx_byte)
                     CMD_READ_ID: state_d = ST_READ_ID;
                     CMD_MATCH: state_d = ST_MATCH;
                     CMD_SKIP: state_d = ST_FUNC_CMD;
                     CMD_SEARCH: state_d = ST_SEARCH;
                     CMD_ALARM_SEARCH: state_d = alarm_q ? ST_SEARCH : ST_HALT;
                     default: state_d = ST_HALT;
                  endcase
               end
               if (state_q == ST_FUNC_CMD && bit_cnt_q == CMD_BITS - 7'd1)
               begin
                  bit_cnt_d = 7'd0;
                  crc_d = 8'h00;
                  case (rx_byte)
                     CMD_CONVERT:
                     begin
                        conv_busy_d = 1'b1;
                        state_d = ST_CONVERT;
                     end
                     CMD_WR_SCRATCH: state_d = ST_WR_SCRATCH;
                     CMD_RD_SCRATCH: state_d = ST_RD_SCRATCH;
                     CMD_COPY:
                     begin
                        nv_d = {cfg_q, low_alarm_threshold_q, high_alarm_threshold_q};
                        state_d = ST_HALT;
                     end
                     CMD_NV_TO_SCRATCH:
                     begin
                        recall_cnt_d = NV_RECALL_CNT;
                        state_d = ST_RECALL;
                     end
                     default: state_d = ST_HALT;
                  endcase
               end
               if (state_q == ST_MATCH && bit_cnt_q == ID_BITS - 7'd1)
               begin
                  bit_cnt_d = 7'd0;
                  // Any mismatch leaves the device deaf until reset
                  state_d = (match_ok_q && slot_wr_bit == id_bit) ? ST_FUNC_CMD : ST_HALT;
               end
               if (state_q == ST_WR_SCRATCH && bit_cnt_q[2:0] == 3'd7)
               begin
                  case (bit_cnt_q[4:3])
                     2'd0: high_alarm_threshold_d = rx_byte;
                     2'd1: low_alarm_threshold_d = rx_byte;
                     default: cfg_d = (rx_byte & CFG_WR_MASK) | CFG_FIXED;
                  endcase
                  if (bit_cnt_q == WR_SCRATCH_BITS - 7'd1)
                  begin
                     state_d = ST_HALT;
                  end
               end
            end
         end
         ST_READ_ID:
         begin
            if (slot_rd_req)
            begin
               bit_cnt_d = bit_cnt_q + 7'd1;
               if (bit_cnt_q == ID_BITS - 7'd1)
               begin
                  bit_cnt_d = 7'd0;
                  state_d = ST_FUNC_CMD;
               end
            end
         end
         ST_SEARCH:
         begin
            // Bit, complement, then the master's choice
            if (phase_q != 2'd2 && slot_rd_req)
            begin
               phase_d = phase_q + 2'd1;
            end
            else if (phase_q == 2'd2 && slot_wr_valid)
            begin
               phase_d = 2'd0;
               bit_cnt_d = bit_cnt_q + 7'd1;
               if (slot_wr_bit != id_bit || bit_cnt_q == ID_BITS - 7'd1)
               begin
                  state_d = ST_HALT;
               end
            end
         end
         ST_RD_SCRATCH:
         begin
            if (slot_rd_req)
            begin
               bit_cnt_d = bit_cnt_q + 7'd1;
               if (bit_cnt_q < CRC_FIRST_BIT)
               begin
                  crc_d = sbtc_crc_step(crc_q, cur_sp_bit);
               end
               if (bit_cnt_q == RD_SCRATCH_BITS - 7'd1)
               begin
                  state_d = ST_HALT;
               end
            end
         end
         ST_CONVERT, ST_RECALL, ST_HALT, ST_IDLE: state_d = state_q;
         default: state_d = ST_HALT;
      endcase
      // A long low wins over everything, abandoning any transfer
      if (line.line_reset)
      begin
         state_d = ST_SEL_CMD;
         bit_cnt_d = 7'd0;
         phase_d = 2'd0;
      end
   end

   // Bit presented to the next read slot; released line reads as 1
   always_comb
   begin
      case (state_q)
         ST_READ_ID: rd_bit_d = id_bit;
         ST_SEARCH: rd_bit_d = (phase_q == 2'd1) ? !id_bit : (phase_q == 2'd0) ? id_bit : 1'b1;
         ST_RD_SCRATCH: rd_bit_d = cur_sp_bit;
         ST_CONVERT: rd_bit_d = !conv_busy_q;
         ST_RECALL: rd_bit_d = !recall_busy;
         default: rd_bit_d = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 7'd0;
         phase_q <= 2'd0;
         shift_q <= 8'h00;
         crc_q <= 8'h00;
         match_ok_q <= 1'b0;
         high_alarm_threshold_q <= HIGH_ALARM_RST;
         low_alarm_threshold_q <= LOW_ALARM_RST;
         cfg_q <= CFG_RST;
         nv_q <= {CFG_RST, LOW_ALARM_RST, HIGH_ALARM_RST};
         recall_cnt_q <= NV_RECALL_CNT;
         conv_busy_q <= 1'b0;
         alarm_q <= 1'b0;
         temp_q <= TEMP_RST;
         rd_bit_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         phase_q <= phase_d;
         shift_q <= shift_d;
         crc_q <= crc_d;
         match_ok_q <= match_ok_d;
         high_alarm_threshold_q <= high_alarm_threshold_d;
         low_alarm_threshold_q <= low_alarm_threshold_d;
         cfg_q <= cfg_d;
         nv_q <= nv_d;
         recall_cnt_q <= recall_cnt_d;
         conv_busy_q <= conv_busy_d;
         alarm_q <= alarm_d;
         temp_q <= temp_d;
         rd_bit_q <= rd_bit_d;
      end
   end

   // Wishbone slave: ack one cycle after the strobe, write at the ack edge
   always_comb
   begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      temp_in_d = temp_in_q;
      dat_d = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_adr_i == REG_TEMP_IN)
      begin
         if (wb_sel_i[0])
         begin
            temp_in_d[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1])
         begin
            temp_in_d[15:8] = wb_dat_i[15:8];
         end
      end
      // Unmapped addresses read zero and still ack
      case (wb_adr_i)
         REG_TEMP_IN: dat_d = {16'h0000, temp_in_q};
         REG_STATUS: dat_d = {24'h000000, state_q, 1'b0, alarm_q, recall_busy, conv_busy_q};
         REG_SCRATCH: dat_d = {8'h00, cfg_q, low_alarm_threshold_q, high_alarm_threshold_q};
         REG_NV: dat_d = {8'h00, nv_q};
         REG_TEMP: dat_d = {16'h0000, temp_q};
         default: dat_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         temp_in_q <= TEMP_RST;
      end
      else
      begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         temp_in_q <= temp_in_d;
      end
   end

   assign slot_rd_bit = rd_bit_q;
   assign conv_active = conv_busy_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule // sbtc_cmd_core
`default_nettype wire

//--- core/sbtc_line_watch.sv
`timescale 1ns/1ps
`default_nettype none
module sbtc_line_watch
   import sbtc_pkg::*;
#(
   parameter int RESET_CYC = RESET_LOW_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dq_in,
   sbtc_line_if.watcher line
);
   logic [19:0] low_cnt_q, low_cnt_d;
   logic long_q, long_d;
   logic pulse_q, pulse_d;

   // Count low time; event fires on release so it lines up with presence
   always_comb
   begin
      low_cnt_d = low_cnt_q;
      long_d = long_q;
      pulse_d = 1'b0;
      if (!dq_in)
      begin
         if (low_cnt_q != 20'hfffff)
         begin
            low_cnt_d = low_cnt_q + 20'd1;
         end
         if (low_cnt_q >= 20'(RESET_CYC))
         begin
            long_d = 1'b1;
         end
      end
      else
      begin
         low_cnt_d = 20'd0;
         long_d = 1'b0;
         pulse_d = long_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         low_cnt_q <= 20'd0;
         long_q <= 1'b0;
         pulse_q <= 1'b0;
      end
      else
      begin
         low_cnt_q <= low_cnt_d;
         long_q <= long_d;
         pulse_q <= pulse_d;
      end
   end

   assign line.line_reset = pulse_q;
endmodule // sbtc_line_watch
`default_nettype wire

//--- sim/sbtc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// Single bus master behind the slot layer; pull-up keeps the line high
module sbtc_bus_master
#(
   parameter int RESET_CYC = 50
)
(
   input wire logic core_clk,
   output logic dq_in,
   output logic slot_wr_valid,
   output logic slot_wr_bit,
   output logic slot_rd_req
);
   int gap = 0;
   initial
   begin
      dq_in = 1'b1;
      slot_wr_valid = 1'b0;
      slot_wr_bit = 1'b0;
      slot_rd_req = 1'b0;
   end
   // Long low, then release before the first slot
   task automatic line_reset();
      @(posedge core_clk);
      dq_in <= 1'b0;
      repeat (RESET_CYC + 10) @(posedge core_clk);
      dq_in <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask
   // Least significant bit first; slow master adds idle gaps
   task automatic wr_bits(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++)
      begin
         repeat (gap + 1) @(posedge core_clk);
         slot_wr_valid <= 1'b1;
         slot_wr_bit <= v[i];
         @(posedge core_clk);
         slot_wr_valid <= 1'b0;
         slot_wr_bit <= ~v[i]; // Stale value never left on the bit
      end
   endtask
   // One read slot; externally powered, so polling is allowed
   task automatic rd_slot();
      repeat (gap + 1) @(posedge core_clk);
      slot_rd_req <= 1'b1;
      @(posedge core_clk);
      slot_rd_req <= 1'b0;
   endtask
endmodule // sbtc_bus_master
`default_nettype wire

//--- sim/sbtc_cmd_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the command core
module sbtc_cmd_core_checker
   import sbtc_pkg::*;
#(
   parameter int RESET_CYC = RESET_LOW_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic dq_in,
   input wire logic slot_wr_valid,
   input wire logic slot_wr_bit,
   input wire logic slot_rd_req,
   input wire logic slot_rd_bit,
   input wire logic conv_active,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   logic [15:0] low_q, low_d;
   logic long_low_end, done_wr, mapped;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Length of the current low stretch, saturating so it never wraps
   always_comb low_d = dq_in ? 16'h0000 : ((&low_q) ? low_q : low_q + 16'h0001);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         low_q <= 16'h0000;
      else
         low_q <= low_d;
   end
   // Release after a low longer than the reset length
   assign long_low_end = dq_in && (low_q > 16'(RESET_CYC));
   assign done_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == REG_CTRL && wb_dat_i[CTRL_CONV_DONE_BIT];
   assign mapped = wb_adr_i inside {REG_TEMP_IN, REG_CTRL, REG_STATUS, REG_SCRATCH, REG_NV, REG_TEMP};
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_unmapped;
      wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_cfg_fixed;
      wb_ack_o && !wb_we_i && wb_adr_i == REG_SCRATCH |-> wb_dat_o[31:23] == 9'h000 && wb_dat_o[20:16] == 5'h1f;
   endproperty
   a_cfg_fixed: assert property (p_cfg_fixed) else $error("fixed config bits changed");
   property p_conv_start;
      $rose(conv_active) |-> $past(slot_wr_valid) || $past(slot_wr_valid, 2);
   endproperty
   a_conv_start: assert property (p_conv_start) else $error("conversion began without command");
   property p_conv_end;
      $fell(conv_active) |-> $past(done_wr) || $past(done_wr, 2);
   endproperty
   a_conv_end: assert property (p_conv_end) else $error("conversion ended without done write");
   property p_line_reset;
      long_low_end |-> ##5 slot_rd_bit;
   endproperty
   a_line_reset: assert property (p_line_reset) else $error("not silent after line reset");
endmodule // sbtc_cmd_core_checker
bind sbtc_cmd_core sbtc_cmd_core_checker #(.RESET_CYC(RESET_CYC)) u_sbtc_cmd_core_checker (
   .core_clk(core_clk), .rst(rst), .dq_in(dq_in), .slot_wr_valid(slot_wr_valid),
   .slot_wr_bit(slot_wr_bit), .slot_rd_req(slot_rd_req), .slot_rd_bit(slot_rd_bit),
   .conv_active(conv_active), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

//--- sim/sensor_bus_transaction_cmds_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_bus_transaction_cmds_tb_top;
   import sbtc_pkg::*;
   localparam int RC = 50;
   localparam logic [7:0] FAM = 8'h3c; // Arbitrary value
   localparam logic [47:0] SER = 48'h00a1b2c3d4e5; // Arbitrary value
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic dq_in, slot_wr_valid, slot_wr_bit, slot_rd_req, slot_rd_bit, conv_active, wb_ack_o, alarm;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   int err_count = 0, n_compared = 0, seed = 80819;
   logic [63:0] id;
   logic [7:0] hi_thr, lo_thr, cfg;
   logic [23:0] nv, wv;
   logic [15:0] temp;
   logic sq[$];
   logic [32:0] w_note, wq[$];
   always #5 core_clk = ~core_clk;
   sbtc_cmd_core #(.RESET_CYC(RC), .FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_sbtc_cmd_core (
      .core_clk(core_clk), .rst(rst), .dq_in(dq_in), .slot_wr_valid(slot_wr_valid),
      .slot_wr_bit(slot_wr_bit), .slot_rd_req(slot_rd_req), .slot_rd_bit(slot_rd_bit),
      .conv_active(conv_active), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   sbtc_bus_master #(.RESET_CYC(RC)) u_sbtc_bus_master (.core_clk(core_clk), .dq_in(dq_in),
      .slot_wr_valid(slot_wr_valid), .slot_wr_bit(slot_wr_bit), .slot_rd_req(slot_rd_req));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Serial CRC, reflected generator, from a zero register
   function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n; i++)
         c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? CRC_POLY_REFL : 8'h00);
      return c;
   endfunction
   task automatic lr();
      u_sbtc_bus_master.line_reset();
   endtask
   task automatic c8(input logic [7:0] b);
      u_sbtc_bus_master.wr_bits({56'h0, b}, 8);
   endtask
   task automatic rb(input logic e);
      sq.push_back(e);
      u_sbtc_bus_master.rd_slot();
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic chk);
      wq.push_back({chk, d});
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= we ? d : 32'h0;
      @(posedge core_clk);
      repeat (100) if (wb_ack_o !== 1'b1) @(posedge core_clk);
      if (wb_ack_o !== 1'b1)
      begin
         err_count++;
         summarize();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask
   // Scratchpad bytes 0..8 as the device should send them
   task automatic sp_rd(input int n);
      logic [71:0] s;
      s[63:0] = {RSVD_BYTE7, RSVD_BYTE6, RSVD_BYTE5, cfg, lo_thr, hi_thr, temp};
      s[71:64] = crc_of(s[63:0], 64);
      for (int i = 0; i < n; i++)
         rb(s[i]);
   endtask
   task automatic wr_scratch();
      wv = 24'($random(seed));
      c8(CMD_WR_SCRATCH);
      u_sbtc_bus_master.wr_bits({40'h0, wv}, 24);
      hi_thr = wv[7:0];
      lo_thr = wv[15:8];
      cfg = (wv[23:16] & CFG_WR_MASK) | CFG_FIXED;
   endtask
   // Results are taken off the queues as they appear
   always @(posedge core_clk)
   begin
      if (slot_rd_req === 1'b1 && sq.size() > 0)
         check("slot_rd_bit", {31'h0, slot_rd_bit}, {31'h0, sq.pop_front()});
      if (wb_ack_o === 1'b1 && wq.size() > 0)
      begin
         w_note = wq.pop_front();
         if (w_note[32])
            check("wb_dat_o", wb_dat_o, w_note[31:0]);
      end
   end
   initial
   begin
      repeat (100000) @(posedge core_clk);
      err_count++;
      summarize();
   end
   initial
   begin
      id = {crc_of({8'h00, SER, FAM}, 56), SER, FAM};
      hi_thr = HIGH_ALARM_RST;
      lo_thr = LOW_ALARM_RST;
      cfg = CFG_RST;
      temp = TEMP_RST;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      wb(1'b0, REG_STATUS, {24'h0, ST_IDLE, 4'h2}, 1'b1);
      repeat (1005) @(posedge core_clk);
      wb(1'b0, REG_SCRATCH, {8'h00, cfg, lo_thr, hi_thr}, 1'b1);
      wb(1'b0, 8'h20, 32'h0, 1'b1);
      c8(CMD_SKIP);
      c8(CMD_RD_SCRATCH);
      rb(1'b1);
      lr();
      c8(CMD_READ_ID);
      for (int i = 0; i < 64; i++)
         rb(id[i]);
      wr_scratch();
      lr();
      c8(CMD_SKIP);
      c8(CMD_RD_SCRATCH);
      sp_rd(72);
      lr();
      c8(CMD_SKIP);
      c8(CMD_RD_SCRATCH);
      sp_rd(4);
      lr();
      c8(CMD_READ_ID);
      rb(id[0]);
      lr();
      c8(CMD_MATCH);
      u_sbtc_bus_master.wr_bits(id ^ 64'h20, 64);
      c8(CMD_CONVERT);
      rb(1'b1);
      check("conv_active", {31'h0, conv_active}, 32'h0);
      lr();
      c8(CMD_MATCH);
      u_sbtc_bus_master.wr_bits(id, 64);
      c8(CMD_CONVERT);
      rb(1'b0);
      temp = 16'($random(seed));
      wb(1'b1, REG_TEMP_IN, {16'h0, temp}, 1'b0);
      wb(1'b1, REG_CTRL, 32'h1, 1'b0);
      rb(1'b1);
      wb(1'b0, REG_TEMP, {16'h0, temp}, 1'b1);
      alarm = ($signed(temp[11:4]) >= $signed(hi_thr)) || ($signed(temp[11:4]) <= $signed(lo_thr));
      lr();
      c8(CMD_ALARM_SEARCH);
      rb(alarm ? id[0] : 1'b1);
      rb(alarm ? ~id[0] : 1'b1);
      lr();
      u_sbtc_bus_master.gap = 4;
      c8(CMD_SKIP);
      c8(CMD_COPY);
      nv = {cfg, lo_thr, hi_thr};
      lr();
      c8(CMD_SKIP);
      wr_scratch();
      lr();
      c8(CMD_SKIP);
      c8(CMD_NV_TO_SCRATCH);
      rb(1'b0);
      repeat (1010) @(posedge core_clk);
      rb(1'b1);
      wb(1'b0, REG_SCRATCH, {8'h00, nv}, 1'b1);
      u_sbtc_bus_master.gap = 0;
      lr();
      c8(CMD_SEARCH);
      for (int i = 0; i < 11; i++)
      begin
         rb(id[i]);
         rb(~id[i]);
         u_sbtc_bus_master.wr_bits({63'h0, (i == 10) ? ~id[i] : id[i]}, 1);
      end
      rb(1'b1);
      lr();
      c8(8'ha5);
      rb(1'b1);
      repeat (4) @(posedge core_clk);
      summarize();
   end
endmodule // sensor_bus_transaction_cmds_tb_top
`default_nettype wire
